// ### hw/uadc_top.sv
// usb attach/detach control: pull-up, power sense, unplug, wake, suspend
// Contract
// - device is only a full-speed peripheral, never a host
// - data-plus pull-up asserted only when ready to enumerate
// - setting picks internal or external pull-up, internal by default
// - self-powered: no pull-up while bus power sense is low
// - bus-power sense read from pin named by its select setting
// - unplug input and wake output each on their own selected pin
// - unplug high: both data lines released, pull-up off
// - unplug low again: pull-up back on, await enumeration
// - wake output only while unplugged; in-band resume blocked then
// - descriptor max power from setting, default 300 mA
// - follow host suspend; bus-powered suspend switches radio and loads off
// - endpoint set selectable: host-transport or audio-class
module uadc_top #(
  parameter int N_PINS = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic [N_PINS-1:0] general_purpose_pin_in,
  output logic [N_PINS-1:0]      general_purpose_pin_out,
  output logic [N_PINS-1:0]      general_purpose_pin_oe_n,
  input  wire logic              bus_suspend,
  input  wire logic              resume_req,
  output logic                   bus_data_plus_oe_n,
  output logic                   bus_data_minus_oe_n,
  output logic                   internal_pullup_en,
  output logic                   resume_allow,
  output logic                   radio_loads_off,
  output logic                   audio_endpoints,
  output logic [9:0]             descriptor_max_power
);

  localparam int PW = uadc_pkg::PIN_W;

  // ****************************************
  // register state
  // ****************************************
  logic [uadc_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [PW-1:0]               pullup_pin_select_r, pullup_pin_select_nxt;
  logic [PW-1:0]               power_sense_pin_select_r, power_sense_pin_select_nxt;
  logic [PW-1:0]               unplug_pin_select_r, unplug_pin_select_nxt;
  logic [PW-1:0]               wake_pin_select_r, wake_pin_select_nxt;
  logic [uadc_pkg::PWR_W-1:0]  max_power_r, max_power_nxt;
  logic [31:0]                 prdata_nxt;
  logic                        pready_nxt;
  logic                        pslverr_nxt;
  logic                        sense_r;
  logic                        unplug_r;
  logic                        wr_ok;
  logic                        mapped;

  uadc_pkg::uadc_state_t state_r, state_nxt;

  uadc_pin_pick #(
    .N_PINS (N_PINS),
    .SEL_W  (PW)
  ) u_sense (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .pins_in  (general_purpose_pin_in),
    .sel      (power_sense_pin_select_r),
    .picked_r (sense_r)
  );

  // unplug input from its own selected pin
  uadc_pin_pick #(
    .N_PINS (N_PINS),
    .SEL_W  (PW)
  ) u_unplug (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .pins_in  (general_purpose_pin_in),
    .sel      (unplug_pin_select_r),
    .picked_r (unplug_r)
  );

  // ****************************************
  // apb slave, zero wait states
  // ****************************************
  always_comb
  begin
    mapped = (paddr == uadc_pkg::ADDR_CTRL) || (paddr == uadc_pkg::ADDR_PINSEL) ||
             (paddr == uadc_pkg::ADDR_POWER) || (paddr == uadc_pkg::ADDR_STATUS);
    wr_ok                      = psel && penable && pwrite && mapped;
    ctrl_nxt                   = ctrl_r;
    pullup_pin_select_nxt      = pullup_pin_select_r;
    power_sense_pin_select_nxt = power_sense_pin_select_r;
    unplug_pin_select_nxt      = unplug_pin_select_r;
    wake_pin_select_nxt        = wake_pin_select_r;
    max_power_nxt              = max_power_r;
    pready_nxt                 = psel && !penable;
    pslverr_nxt                = psel && !penable && !mapped;
    prdata_nxt                 = 32'h0000_0000;
    if (wr_ok && paddr == uadc_pkg::ADDR_CTRL)
      ctrl_nxt = pwdata[uadc_pkg::CTRL_W-1:0];
    if (wr_ok && paddr == uadc_pkg::ADDR_PINSEL)
    begin
      pullup_pin_select_nxt      = pwdata[uadc_pkg::PSEL_PULLUP_LSB +: PW];
      power_sense_pin_select_nxt = pwdata[uadc_pkg::PSEL_SENSE_LSB +: PW];
      unplug_pin_select_nxt      = pwdata[uadc_pkg::PSEL_UNPLUG_LSB +: PW];
      wake_pin_select_nxt        = pwdata[uadc_pkg::PSEL_WAKE_LSB +: PW];
    end
    if (wr_ok && paddr == uadc_pkg::ADDR_POWER)
      max_power_nxt = pwdata[uadc_pkg::PWR_W-1:0];
    // wake request self-clears once unplug drops
    if (!unplug_r && state_r == uadc_pkg::UADC_IDLE)
      ctrl_nxt[uadc_pkg::CTRL_WAKE_REQ] = 1'b0;
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        uadc_pkg::ADDR_CTRL:   prdata_nxt[uadc_pkg::CTRL_W-1:0] = ctrl_r;
        uadc_pkg::ADDR_PINSEL:
        begin
          prdata_nxt[uadc_pkg::PSEL_PULLUP_LSB +: PW] = pullup_pin_select_r;
          prdata_nxt[uadc_pkg::PSEL_SENSE_LSB +: PW]  = power_sense_pin_select_r;
          prdata_nxt[uadc_pkg::PSEL_UNPLUG_LSB +: PW] = unplug_pin_select_r;
          prdata_nxt[uadc_pkg::PSEL_WAKE_LSB +: PW]   = wake_pin_select_r;
        end
        uadc_pkg::ADDR_POWER:  prdata_nxt[uadc_pkg::PWR_W-1:0] = max_power_r;
        uadc_pkg::ADDR_STATUS:
        begin
          prdata_nxt[uadc_pkg::ST_ATTACHED]  = (state_r == uadc_pkg::UADC_ATTACHED);
          prdata_nxt[uadc_pkg::ST_UNPLUGGED] = unplug_r;
          prdata_nxt[uadc_pkg::ST_SENSE]     = sense_r;
          prdata_nxt[uadc_pkg::ST_SUSPENDED] = (state_r == uadc_pkg::UADC_SUSPENDED);
          prdata_nxt[uadc_pkg::ST_WAKE]      = (state_r == uadc_pkg::UADC_WAKING);
          prdata_nxt[uadc_pkg::ST_STATE_LSB +: $bits(state_r)] = state_r;
        end
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_r                   <= uadc_pkg::CTRL_RESET;
      pullup_pin_select_r      <= uadc_pkg::PULLUP_PIN_RESET;
      power_sense_pin_select_r <= uadc_pkg::SENSE_PIN_RESET;
      unplug_pin_select_r      <= uadc_pkg::UNPLUG_PIN_RESET;
      wake_pin_select_r        <= uadc_pkg::WAKE_PIN_RESET;
      max_power_r              <= uadc_pkg::MAX_POWER_RESET;
      pready                   <= 1'b0;
      pslverr                  <= 1'b0;
      prdata                   <= 32'h0000_0000;
    end
    else
    begin
      ctrl_r                   <= ctrl_nxt;
      pullup_pin_select_r      <= pullup_pin_select_nxt;
      power_sense_pin_select_r <= power_sense_pin_select_nxt;
      unplug_pin_select_r      <= unplug_pin_select_nxt;
      wake_pin_select_r        <= wake_pin_select_nxt;
      max_power_r              <= max_power_nxt;
      pready                   <= pready_nxt;
      pslverr                  <= pslverr_nxt;
      prdata                   <= prdata_nxt;
    end
  end

  // ****************************************
  // connection state machine
  // ****************************************
  logic attach_ok;
  logic pu_on;
  logic lines_oe_n_nxt;
  logic int_pu_nxt;
  logic [N_PINS-1:0] gp_out_nxt, gp_oe_n_nxt;
  logic resume_nxt, loads_off_nxt;

  always_comb
  begin
    // attach only when ready and, if self-powered, power present
    attach_ok = ctrl_r[uadc_pkg::CTRL_READY] && !unplug_r &&
                (!ctrl_r[uadc_pkg::CTRL_SELF_PWR] || sense_r);
    state_nxt = state_r;
    case (state_r)
      uadc_pkg::UADC_IDLE:
        if (unplug_r)
          state_nxt = uadc_pkg::UADC_DETACHED;
        else if (attach_ok)
          state_nxt = uadc_pkg::UADC_ATTACHED;
      uadc_pkg::UADC_ATTACHED:
        if (!attach_ok)
          state_nxt = unplug_r ? uadc_pkg::UADC_DETACHED : uadc_pkg::UADC_IDLE;
        else if (bus_suspend)
          state_nxt = uadc_pkg::UADC_SUSPENDED;
      uadc_pkg::UADC_SUSPENDED:
        if (!attach_ok)
          state_nxt = unplug_r ? uadc_pkg::UADC_DETACHED : uadc_pkg::UADC_IDLE;
        else if (!bus_suspend)
          state_nxt = uadc_pkg::UADC_ATTACHED;
      uadc_pkg::UADC_DETACHED:
        if (!unplug_r)
          state_nxt = uadc_pkg::UADC_IDLE;
        else if (ctrl_r[uadc_pkg::CTRL_WAKE_REQ])
          state_nxt = uadc_pkg::UADC_WAKING;
      uadc_pkg::UADC_WAKING:
        if (!unplug_r)
          state_nxt = uadc_pkg::UADC_IDLE;
      default:
        state_nxt = uadc_pkg::UADC_IDLE;
    endcase

    pu_on = (state_nxt == uadc_pkg::UADC_ATTACHED) || (state_nxt == uadc_pkg::UADC_SUSPENDED);
    lines_oe_n_nxt = !pu_on;
    int_pu_nxt = pu_on && !ctrl_r[uadc_pkg::CTRL_EXT_PU];
    gp_out_nxt  = '0;
    gp_oe_n_nxt = '1;
    // external pull-up pin driven high or released
    if (pu_on && ctrl_r[uadc_pkg::CTRL_EXT_PU])
    begin
      gp_out_nxt[pullup_pin_select_r]  = 1'b1;
      gp_oe_n_nxt[pullup_pin_select_r] = 1'b0;
    end
    // wake output on its pin, only while unplugged
    gp_oe_n_nxt[wake_pin_select_r] = 1'b0;
    gp_out_nxt[wake_pin_select_r]  = (state_nxt == uadc_pkg::UADC_WAKING);
    resume_nxt = resume_req && (state_nxt == uadc_pkg::UADC_SUSPENDED);
    // bus-powered suspend turns radio and loads off
    loads_off_nxt = (state_nxt == uadc_pkg::UADC_SUSPENDED) && !ctrl_r[uadc_pkg::CTRL_SELF_PWR];
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r                  <= uadc_pkg::UADC_IDLE;
      bus_data_plus_oe_n       <= 1'b1;
      bus_data_minus_oe_n      <= 1'b1;
      internal_pullup_en       <= 1'b0;
      general_purpose_pin_out  <= '0;
      general_purpose_pin_oe_n <= '1;
      resume_allow             <= 1'b0;
      radio_loads_off          <= 1'b0;
      audio_endpoints          <= 1'b0;
      descriptor_max_power     <= uadc_pkg::MAX_POWER_RESET;
    end
    else
    begin
      state_r                  <= state_nxt;
      // peripheral only: lines enabled only when attached or suspended
      bus_data_plus_oe_n       <= lines_oe_n_nxt;
      bus_data_minus_oe_n      <= lines_oe_n_nxt;
      internal_pullup_en       <= int_pu_nxt;
      general_purpose_pin_out  <= gp_out_nxt;
      general_purpose_pin_oe_n <= gp_oe_n_nxt;
      resume_allow             <= resume_nxt;
      radio_loads_off          <= loads_off_nxt;
      audio_endpoints          <= ctrl_r[uadc_pkg::CTRL_AUDIO_EP];
      descriptor_max_power     <= max_power_r;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_pullup_needs_power: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ctrl_r[uadc_pkg::CTRL_SELF_PWR] && !sense_r) |=> !internal_pullup_en)
    else $error("pull-up on without bus power");
  a_unplug_releases: assert property (@(posedge clk_sys) disable iff (!arst_n)
    unplug_r |=> (bus_data_plus_oe_n && bus_data_minus_oe_n && !internal_pullup_en))
    else $error("lines driven while unplugged");
  a_reconnect_after: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ($fell(unplug_r) && ctrl_r[uadc_pkg::CTRL_READY] && !ctrl_r[uadc_pkg::CTRL_SELF_PWR]
     && !ctrl_r[uadc_pkg::CTRL_EXT_PU] && $stable(ctrl_r)) |-> ##[1:3] internal_pullup_en)
    else $error("no reconnect after unplug");
  a_wake_only_unplug: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (state_r == uadc_pkg::UADC_WAKING) |-> $past(unplug_r))
    else $error("wake without unplug");
  a_no_resume_unplug: assert property (@(posedge clk_sys) disable iff (!arst_n)
    unplug_r |=> !resume_allow)
    else $error("resume while unplugged");
  a_internal_default: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ctrl_r[uadc_pkg::CTRL_EXT_PU] |=> !internal_pullup_en)
    else $error("internal pull-up with external chosen");
  a_power_follows: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ##1 descriptor_max_power == $past(max_power_r))
    else $error("power descriptor mismatch");
  a_suspend_loads: assert property (@(posedge clk_sys) disable iff (!arst_n)
    radio_loads_off |-> (state_r == uadc_pkg::UADC_SUSPENDED))
    else $error("loads off outside suspend");
  a_pullup_ready: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !ctrl_r[uadc_pkg::CTRL_READY] |=> !internal_pullup_en)
    else $error("pull-up before ready");

endmodule : uadc_top

// ### hw/uadc_pkg.sv
// package of constants for the usb attach/detach control block
package uadc_pkg;

  // ****************************************
  // apb register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_PINSEL  = 8'h04;
  localparam logic [7:0] ADDR_POWER   = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_SUSPCTL = 8'h10;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int CTRL_READY    = 0;
  localparam int CTRL_EXT_PU   = 1;
  localparam int CTRL_SELF_PWR = 2;
  localparam int CTRL_AUDIO_EP = 3;
  localparam int CTRL_WAKE_REQ = 4;
  localparam int CTRL_W        = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  // ****************************************
  // pin select fields (3 bits each, one per byte)
  // ****************************************
  localparam int PIN_W          = 3;
  localparam int PSEL_PULLUP_LSB = 0;
  localparam int PSEL_SENSE_LSB  = 8;
  localparam int PSEL_UNPLUG_LSB = 16;
  localparam int PSEL_WAKE_LSB   = 24;
  localparam logic [PIN_W-1:0] PULLUP_PIN_RESET = 3'h0;
  localparam logic [PIN_W-1:0] SENSE_PIN_RESET  = 3'h1;
  localparam logic [PIN_W-1:0] UNPLUG_PIN_RESET = 3'h2;
  localparam logic [PIN_W-1:0] WAKE_PIN_RESET   = 3'h3;

  // ****************************************
  // power descriptor, milliamps
  // ****************************************
  localparam int PWR_W = 10;
  localparam logic [PWR_W-1:0] MAX_POWER_RESET = 10'h12C;

  // ****************************************
  // status fields
  // ****************************************
  localparam int ST_ATTACHED  = 0;
  localparam int ST_UNPLUGGED = 1;
  localparam int ST_SENSE     = 2;
  localparam int ST_SUSPENDED = 3;
  localparam int ST_WAKE      = 4;
  localparam int ST_STATE_LSB = 8;

  typedef enum logic [2:0] {
    UADC_IDLE,
    UADC_ATTACHED,
    UADC_SUSPENDED,
    UADC_DETACHED,
    UADC_WAKING
  } uadc_state_t;

endpackage : uadc_pkg

// ### hw/uadc_pin_pick.sv
// one-of-n pin picker: reads an input pin chosen by an index
module uadc_pin_pick #(
  parameter int N_PINS = 8,
  parameter int SEL_W  = 3
) (
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic [N_PINS-1:0] pins_in,
  input  wire logic [SEL_W-1:0]  sel,
  output logic                   picked_r
);

  logic picked_nxt;

  always_comb
  begin
    picked_nxt = pins_in[sel];
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      picked_r <= 1'b0;
    else
      picked_r <= picked_nxt;
  end

endmodule : uadc_pin_pick

// ### testbench/uadc_host_model.sv
// host or hub controller model: drives unplug, power sense and suspend
module uadc_host_model (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic unplug_req,
  input  wire logic slow,
  input  wire logic power_on,
  input  wire logic suspend_req,
  input  wire logic wake_level,
  output logic      unplug,
  output logic      power_sense,
  output logic      bus_suspend
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] wait_r;
  logic       woken_r;

  assign unplug = unplug_req && !woken_r;
  assign power_sense = power_on;
  assign bus_suspend = suspend_req;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wait_r  <= 4'h0;
      woken_r <= 1'b0;
    end
    else if (!unplug_req)
    begin
      wait_r  <= 4'h0;
      woken_r <= 1'b0;
    end
    else if (wake_level && !woken_r)
    begin
      wait_r  <= wait_r + 4'h1;
      woken_r <= (wait_r == (slow ? 4'hB : 4'h1));
    end
  end
endmodule : uadc_host_model

// ### testbench/tb_usb_attach_detach_control.sv
// self-checking bench for the usb attach/detach control block
module tb_usb_attach_detach_control;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_sys = 1'b0;
  logic              arst_n = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic              pready, pslverr, rerr;
  logic [31:0]       prdata, rd;
  logic [7:0]        pin_in, pin_out, pin_oe_n;
  logic              dp_oe_n, dm_oe_n, pu_en, res_ok, loads_off, audio_ep, bus_suspend, unplug, power_sense;
  logic [9:0]        max_pwr;
  logic              resume_req = 1'b0;
  logic              unplug_req = 1'b0;
  logic              slow = 1'b0;
  logic              power_on = 1'b0;
  logic              suspend_req = 1'b0;
  int                sense_idx = 1;
  int                unplug_idx = 2;
  int                wake_idx = 3;
  int                error_cnt = 0;
  int                compares = 0;
  int                cycles = 0;
  wire logic         wake_level = !pin_oe_n[wake_idx] && pin_out[wake_idx];

  always #10 clk_sys = ~clk_sys;

  // pins released by the block are driven by the host or pulled down
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (i == sense_idx) pin_in[i] = power_sense;
      else if (i == unplug_idx) pin_in[i] = unplug;
      else pin_in[i] = 1'b0;
  end

  uadc_top #(.N_PINS(8)) uadc_top_inst (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .general_purpose_pin_in(pin_in), .general_purpose_pin_out(pin_out), .general_purpose_pin_oe_n(pin_oe_n),
    .bus_suspend(bus_suspend), .resume_req(resume_req), .bus_data_plus_oe_n(dp_oe_n),
    .bus_data_minus_oe_n(dm_oe_n), .internal_pullup_en(pu_en), .resume_allow(res_ok),
    .radio_loads_off(loads_off), .audio_endpoints(audio_ep), .descriptor_max_power(max_pwr));

  uadc_host_model uadc_host_model_inst (.clk_sys(clk_sys), .arst_n(arst_n), .unplug_req(unplug_req),
    .slow(slow), .power_on(power_on), .suspend_req(suspend_req), .wake_level(wake_level),
    .unplug(unplug), .power_sense(power_sense), .bus_suspend(bus_suspend));

  // ****************
  // helpers
  // ****************
  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %0b seen %0b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp, input logic experr);
    apb(1'b0, addr, 32'h0);
    chk_word("read data", exp, rd);
    chk_bit("slave error", experr, rerr);
  endtask : rdchk

  task automatic settle();
    repeat (3) @(posedge clk_sys);
  endtask : settle

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    rdchk(uadc_pkg::ADDR_CTRL, 32'h0, 1'b0);
    rdchk(uadc_pkg::ADDR_PINSEL, 32'h03020100, 1'b0);
    rdchk(uadc_pkg::ADDR_POWER, 32'h12C, 1'b0);
    rdchk(8'h14, 32'h0, 1'b1);
    chk_word("max power", 32'h12C, {22'h0, max_pwr});
    chk_bit("pullup before ready", 1'b0, pu_en);
    chk_bit("data plus released", 1'b1, dp_oe_n);
  endtask : t_reset

  task automatic t_internal();
    apb(1'b1, uadc_pkg::ADDR_CTRL, 32'h1);
    settle();
    chk_bit("internal pullup", 1'b1, pu_en);
    chk_bit("data plus driven", 1'b0, dp_oe_n);
    chk_bit("pullup pin idle", 1'b1, pin_oe_n[0]);
    rdchk(uadc_pkg::ADDR_STATUS, (32'(uadc_pkg::UADC_ATTACHED) << uadc_pkg::ST_STATE_LSB) |
          (32'h1 << uadc_pkg::ST_ATTACHED), 1'b0);
    apb(1'b1, uadc_pkg::ADDR_CTRL, 32'h9);
    settle();
    chk_bit("audio set", 1'b1, audio_ep);
    apb(1'b1, uadc_pkg::ADDR_CTRL, 32'h1);
    settle();
    chk_bit("transport set", 1'b0, audio_ep);
    apb(1'b1, uadc_pkg::ADDR_POWER, 32'h64);
    settle();
    chk_word("max power", 32'h64, {22'h0, max_pwr});
  endtask : t_internal

  task automatic t_external();
    power_on <= 1'b0;
    apb(1'b1, uadc_pkg::ADDR_CTRL, 32'h7);
    settle();
    chk_bit("no internal pullup", 1'b0, pu_en);
    chk_bit("pin released no power", 1'b1, pin_oe_n[0]);
    power_on <= 1'b1;
    settle();
    chk_bit("pin driven", 1'b0, pin_oe_n[0]);
    chk_bit("pin high", 1'b1, pin_out[0]);
    sense_idx = 5;
    apb(1'b1, uadc_pkg::ADDR_PINSEL, 32'h03020504);
    settle();
    chk_bit("new pin driven", 1'b0, pin_oe_n[4]);
    chk_bit("old pin released", 1'b1, pin_oe_n[0]);
    power_on <= 1'b0;
    settle();
    chk_bit("new pin released", 1'b1, pin_oe_n[4]);
  endtask : t_external

  task automatic t_unplug();
    power_on <= 1'b1;
    unplug_idx = 6;
    wake_idx = 7;
    apb(1'b1, uadc_pkg::ADDR_PINSEL, 32'h07060504);
    apb(1'b1, uadc_pkg::ADDR_CTRL, 32'h1);
    slow <= 1'b1;
    unplug_req <= 1'b1;
    settle();
    chk_bit("pullup off", 1'b0, pu_en);
    chk_bit("plus released", 1'b1, dp_oe_n);
    chk_bit("minus released", 1'b1, dm_oe_n);
    chk_bit("wake low", 1'b0, wake_level);
    apb(1'b1, uadc_pkg::ADDR_CTRL, 32'h11);
    settle();
    chk_bit("wake high", 1'b1, wake_level);
    rdchk(uadc_pkg::ADDR_STATUS, (32'(uadc_pkg::UADC_WAKING) << uadc_pkg::ST_STATE_LSB) |
          (32'h1 << uadc_pkg::ST_UNPLUGGED) | (32'h1 << uadc_pkg::ST_SENSE) | (32'h1 << uadc_pkg::ST_WAKE), 1'b0);
    while (unplug === 1'b1)
      @(posedge clk_sys);
    settle();
    chk_bit("wake back low", 1'b0, wake_level);
    chk_bit("pullup back", 1'b1, pu_en);
    chk_bit("plus driven", 1'b0, dp_oe_n);
    rdchk(uadc_pkg::ADDR_CTRL, 32'h1, 1'b0);
    unplug_req <= 1'b0;
    settle();
  endtask : t_unplug

  task automatic t_suspend();
    suspend_req <= 1'b1;
    resume_req <= 1'b1;
    settle();
    chk_bit("loads off", 1'b1, loads_off);
    chk_bit("resume allowed", 1'b1, res_ok);
    rdchk(uadc_pkg::ADDR_STATUS, (32'(uadc_pkg::UADC_SUSPENDED) << uadc_pkg::ST_STATE_LSB) |
          (32'h1 << uadc_pkg::ST_SENSE) | (32'h1 << uadc_pkg::ST_SUSPENDED), 1'b0);
    apb(1'b1, uadc_pkg::ADDR_CTRL, 32'h5);
    settle();
    chk_bit("self powered loads", 1'b0, loads_off);
    slow <= 1'b0;
    unplug_req <= 1'b1;
    settle();
    chk_bit("no resume unplugged", 1'b0, res_ok);
    unplug_req <= 1'b0;
    suspend_req <= 1'b0;
    settle();
    chk_bit("no resume awake", 1'b0, res_ok);
  endtask : t_suspend

  initial
  begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_internal();
    t_external();
    t_unplug();
    t_suspend();
    end_of_test();
  end
endmodule : tb_usb_attach_detach_control
